/* File: rtl/low_vector_exception_unit.sv */
// Recognition and classification of exception vectors zero to four
`timescale 1ns/1ps
`include "low_vector_defines.svh"

module low_vector_exception_unit #(
   parameter logic [7:0] BRK_OPCODE = 8'hfe
) (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         arst_n,
   // Instruction pipeline
   input  wire low_vector_pkg::instr_info_t  instr,
   input  wire low_vector_pkg::debug_cond_t  dbg,
   input  wire logic                         instr_valid,
   output logic                              instr_ready,
   output logic                              instr_commit,
   output logic                              instr_squash,
   // Unmaskable interrupt sources
   input  wire logic                         nmi_pin,
   input  wire logic                         lic_nmi_req,
   // Delivery logic
   output low_vector_pkg::exc_req_t          exc_req,
   output logic                              exc_req_valid,
   input  wire logic                         exc_req_ready,
   // Status
   input  wire logic [5:0]                   debug_status_clr,
   output low_vector_pkg::debug_cond_t       debug_status_reg,
   output low_vector_pkg::flags_t            processor_flags_reg
);

   localparam int W = low_vector_pkg::DATA_W;

   // Pin synchroniser, change counts when stages two and three agree
   logic       nmi_s1_reg;
   logic       nmi_s2_reg;
   logic       nmi_s3_reg;
   logic       nmi_lvl_reg;
   logic       nmi_rise;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_s1_reg  <= 1'b0;
         nmi_s2_reg  <= 1'b0;
         nmi_s3_reg  <= 1'b0;
         nmi_lvl_reg <= 1'b0;
      end else begin
         nmi_s1_reg <= nmi_pin;
         nmi_s2_reg <= nmi_s1_reg;
         nmi_s3_reg <= nmi_s2_reg;
         if (nmi_s2_reg == nmi_s3_reg) begin
            nmi_lvl_reg <= nmi_s3_reg;
         end
      end
   end

   assign nmi_rise = (nmi_s2_reg == nmi_s3_reg) & nmi_s3_reg & ~nmi_lvl_reg;

   // Helpers
   logic       div_fault;
   logic       ar_carry;
   logic       ar_ovf;

   quotient_check #(.W(W)) i_quotient_check (
      .dividend  ({instr.opnd_hi, instr.opnd_a}),
      .divisor   (instr.opnd_b),
      .is_signed (instr.op == low_vector_pkg::op_sdiv),
      .fault     (div_fault)
   );

   arith_flags #(.W(W)) i_arith_flags (
      .a     (instr.opnd_a),
      .b     (instr.opnd_b),
      .sub   (instr.op == low_vector_pkg::op_sub),
      .carry (ar_carry),
      .ovf   (ar_ovf)
   );

   // Registers
   logic                          req_valid_reg;
   low_vector_pkg::exc_req_t      req_reg;
   logic                          pend_dbg_reg;
   logic                          pend_nmi_reg;
   logic [low_vector_pkg::ADDR_W-1:0] boundary_reg;
   logic                          ready_reg;
   logic                          commit_reg;
   logic                          squash_reg;
   low_vector_pkg::debug_cond_t   dstat_reg;
   low_vector_pkg::flags_t        flags_reg;

   // Decode
   wire accept     = instr_valid & ready_reg;
   wire is_div     = (instr.op == low_vector_pkg::op_udiv) |
                     (instr.op == low_vector_pkg::op_sdiv);
   wire fault_dbg  = accept & (dbg.fetch_brk | dbg.gen_detect);
   wire fault_div  = accept & ~fault_dbg & is_div & div_fault;
   wire fault_any  = fault_dbg | fault_div;
   wire completes  = accept & ~fault_any;
   wire is_brk     = instr.opcode == BRK_OPCODE;
   wire is_int3    = (instr.op == low_vector_pkg::op_intn) &
                     (instr.imm == `INTN_BRK_IMM);
   wire trap_brk   = completes & (is_brk | is_int3);
   wire trap_ovf   = completes & ~trap_brk &
                     (instr.op == low_vector_pkg::op_into) &
                     flags_reg.signed_overflow_flag;
   wire dbg_trap   = completes & (dbg.data_brk | dbg.io_brk |
                     dbg.single_step | dbg.task_switch);
   wire is_arith   = (instr.op == low_vector_pkg::op_add) |
                     (instr.op == low_vector_pkg::op_sub);
   wire [low_vector_pkg::ADDR_W-1:0] after_addr =
      is_brk ? instr.addr + `BRK_INSTR_LEN : instr.next_addr;
   wire slot_free  = ~req_valid_reg | exc_req_ready;
   wire take_pdbg  = ~accept & slot_free & pend_dbg_reg;
   wire take_nmi   = ~accept & slot_free & ~pend_dbg_reg & pend_nmi_reg;
   wire nmi_set    = nmi_rise | lic_nmi_req;

   // Request selection
   low_vector_pkg::exc_req_t req_next;
   logic                     issue;

   always_comb begin
      issue              = 1'b1;
      req_next           = req_reg;
      req_next.err_code_valid = 1'b0;
      if (fault_dbg) begin
         req_next.vector    = `VEC_DEBUG;
         req_next.cls       = low_vector_pkg::cls_fault;
         req_next.save_addr = instr.addr;
      end else if (fault_div) begin
         req_next.vector    = `VEC_QUOTIENT;
         req_next.cls       = low_vector_pkg::cls_fault;
         req_next.save_addr = instr.addr;
      end else if (trap_brk | trap_ovf) begin
         req_next.vector    = trap_brk ? `VEC_BREAKPOINT : `VEC_OVERFLOW;
         req_next.cls       = low_vector_pkg::cls_trap;
         req_next.save_addr = after_addr;
      end else if (dbg_trap) begin
         req_next.vector    = `VEC_DEBUG;
         req_next.cls       = low_vector_pkg::cls_trap;
         req_next.save_addr = after_addr;
      end else if (take_pdbg) begin
         req_next.vector    = `VEC_DEBUG;
         req_next.cls       = low_vector_pkg::cls_trap;
         req_next.save_addr = boundary_reg;
      end else if (take_nmi) begin
         req_next.vector    = `VEC_NMI;
         req_next.cls       = low_vector_pkg::cls_none;
         req_next.save_addr = boundary_reg;
      end else begin
         issue              = 1'b0;
      end
   end

   wire req_valid_next = issue | (req_valid_reg & ~exc_req_ready);
   wire pend_dbg_next  = (dbg_trap & (trap_brk | trap_ovf)) |
                         (pend_dbg_reg & ~take_pdbg);
   wire pend_nmi_next  = nmi_set | (pend_nmi_reg & ~take_nmi);
   wire busy_next      = req_valid_next | pend_dbg_next | pend_nmi_next;

   // Causes recorded into debug status, set wins over clear
   low_vector_pkg::debug_cond_t dset;
   assign dset.fetch_brk   = fault_dbg & dbg.fetch_brk;
   assign dset.gen_detect  = fault_dbg & dbg.gen_detect;
   assign dset.data_brk    = completes & dbg.data_brk;
   assign dset.io_brk      = completes & dbg.io_brk;
   assign dset.single_step = completes & dbg.single_step;
   assign dset.task_switch = completes & dbg.task_switch;

   wire [5:0] dstat_next = (dstat_reg & ~debug_status_clr) | dset;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_valid_reg <= 1'b0;
         req_reg       <= '0;
         pend_dbg_reg  <= 1'b0;
         pend_nmi_reg  <= 1'b0;
         boundary_reg  <= '0;
         ready_reg     <= 1'b0;
         commit_reg    <= 1'b0;
         squash_reg    <= 1'b0;
         dstat_reg     <= `DEBUG_STATUS_RST;
         flags_reg     <= `FLAGS_RST;
      end else begin
         req_valid_reg <= req_valid_next;
         if (issue) begin
            req_reg <= req_next;
         end
         pend_dbg_reg  <= pend_dbg_next;
         pend_nmi_reg  <= pend_nmi_next;
         ready_reg     <= ~busy_next;
         commit_reg    <= completes;
         squash_reg    <= fault_any;
         dstat_reg     <= dstat_next;
         if (fault_any) begin
            boundary_reg <= instr.addr;
         end else if (completes) begin
            boundary_reg <= after_addr;
         end
         if (completes & is_arith & ~is_brk) begin
            flags_reg <= {ar_ovf, ar_carry};
         end
      end
   end

   assign instr_ready         = ready_reg;
   assign instr_commit        = commit_reg;
   assign instr_squash        = squash_reg;
   assign exc_req             = req_reg;
   assign exc_req_valid       = req_valid_reg;
   assign debug_status_reg    = dstat_reg;
   assign processor_flags_reg = flags_reg;

   // Checks
   property p_div_fault;
      @(posedge core_clk) disable iff (!arst_n)
      fault_div |=> exc_req_valid && exc_req.vector == `VEC_QUOTIENT &&
         exc_req.cls == low_vector_pkg::cls_fault &&
         exc_req.save_addr == $past(instr.addr) && !exc_req.err_code_valid;
   endproperty
   a_div_fault: assert property (p_div_fault)
      else $error("divide fault not raised as expected");

   property p_div_squash;
      @(posedge core_clk) disable iff (!arst_n)
      fault_div |=> instr_squash && !instr_commit ##1 !instr_squash;
   endproperty
   a_div_squash: assert property (p_div_squash)
      else $error("faulting divide was not squashed");

   property p_dbg_fault;
      @(posedge core_clk) disable iff (!arst_n)
      accept && dbg.fetch_brk |=> exc_req.vector == `VEC_DEBUG &&
         exc_req.cls == low_vector_pkg::cls_fault &&
         exc_req.save_addr == $past(instr.addr) && instr_squash;
   endproperty
   a_dbg_fault: assert property (p_dbg_fault)
      else $error("fetch breakpoint not a fault on its own address");

   property p_dbg_trap;
      @(posedge core_clk) disable iff (!arst_n)
      dbg_trap && !trap_brk && !trap_ovf |=> instr_commit &&
         exc_req_valid && exc_req.cls == low_vector_pkg::cls_trap &&
         exc_req.save_addr == $past(after_addr);
   endproperty
   a_dbg_trap: assert property (p_dbg_trap)
      else $error("debug trap class or address wrong");

   property p_dbg_status;
      @(posedge core_clk) disable iff (!arst_n)
      completes && dbg.single_step |=> debug_status_reg.single_step;
   endproperty
   a_dbg_status: assert property (p_dbg_status)
      else $error("single step cause not recorded");

   property p_brk;
      @(posedge core_clk) disable iff (!arst_n)
      completes && is_brk |=> exc_req_valid &&
         exc_req.vector == `VEC_BREAKPOINT &&
         exc_req.save_addr == $past(instr.addr) + `BRK_INSTR_LEN &&
         $stable(processor_flags_reg);
   endproperty
   a_brk: assert property (p_brk)
      else $error("breakpoint address or state wrong");

   property p_into;
      @(posedge core_clk) disable iff (!arst_n)
      completes && instr.op == low_vector_pkg::op_into && !is_brk |=>
         (exc_req_valid && exc_req.vector == `VEC_OVERFLOW) ==
         $past(flags_reg.signed_overflow_flag);
   endproperty
   a_into: assert property (p_into)
      else $error("overflow check did not follow the flag");

   property p_nmi;
      @(posedge core_clk) disable iff (!arst_n)
      lic_nmi_req && instr_ready && !instr_valid |=> !instr_ready ##1
         exc_req_valid && exc_req.vector == `VEC_NMI &&
         exc_req.cls == low_vector_pkg::cls_none;
   endproperty
   a_nmi: assert property (p_nmi)
      else $error("unmaskable request not delivered in two cycles");

   property p_nmi_complete;
      @(posedge core_clk) disable iff (!arst_n)
      nmi_set && completes |=> instr_commit && pend_nmi_reg;
   endproperty
   a_nmi_complete: assert property (p_nmi_complete)
      else $error("instruction not completed ahead of unmaskable request");

   property p_flags;
      @(posedge core_clk) disable iff (!arst_n)
      completes && instr.op == low_vector_pkg::op_add && !is_brk |=>
         processor_flags_reg == {$past(ar_ovf), $past(ar_carry)};
   endproperty
   a_flags: assert property (p_flags)
      else $error("add did not update the flags");

   property p_hold;
      @(posedge core_clk) disable iff (!arst_n)
      exc_req_valid && !exc_req_ready |=> exc_req_valid && $stable(exc_req);
   endproperty
   a_hold: assert property (p_hold)
      else $error("request changed before it was taken");

   c_div:  cover property (@(posedge core_clk) disable iff (!arst_n)
                           fault_div);
   c_brk:  cover property (@(posedge core_clk) disable iff (!arst_n)
                           trap_brk && dbg_trap);
   c_nmi:  cover property (@(posedge core_clk) disable iff (!arst_n)
                           take_nmi);
   c_into: cover property (@(posedge core_clk) disable iff (!arst_n)
                           trap_ovf);

endmodule : low_vector_exception_unit

/* File: rtl/low_vector_defines.svh */
// Vector numbers, decode constants and reset values of the exception unit
`ifndef LOW_VECTOR_DEFINES_SVH
`define LOW_VECTOR_DEFINES_SVH

`define VEC_QUOTIENT    8'h00
`define VEC_DEBUG       8'h01
`define VEC_NMI         8'h02
`define VEC_BREAKPOINT  8'h03
`define VEC_OVERFLOW    8'h04

`define INTN_BRK_IMM    8'h03
`define BRK_INSTR_LEN   32'h0000_0001

`define DEBUG_STATUS_RST 6'h00
`define FLAGS_RST        2'h0

`endif

/* File: rtl/low_vector_pkg.sv */
// Types shared by the exception unit and its pipeline neighbours
package low_vector_pkg;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   typedef enum logic [2:0] {
      op_other,
      op_udiv,
      op_sdiv,
      op_intn,
      op_into,
      op_add,
      op_sub
   } op_t;

   typedef enum logic [1:0] {
      cls_none,
      cls_fault,
      cls_trap
   } exc_class_t;

   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [ADDR_W-1:0]   next_addr;
      op_t                 op;
      logic [7:0]          opcode;
      logic [7:0]          imm;
      logic [DATA_W-1:0]   opnd_hi;
      logic [DATA_W-1:0]   opnd_a;
      logic [DATA_W-1:0]   opnd_b;
   } instr_info_t;

   typedef struct packed {
      logic task_switch;
      logic single_step;
      logic gen_detect;
      logic io_brk;
      logic data_brk;
      logic fetch_brk;
   } debug_cond_t;

   typedef struct packed {
      logic signed_overflow_flag;
      logic carry_flag;
   } flags_t;

   typedef struct packed {
      logic [7:0]          vector;
      exc_class_t          cls;
      logic                err_code_valid;
      logic [ADDR_W-1:0]   save_addr;
   } exc_req_t;

endpackage : low_vector_pkg

/* File: rtl/quotient_check.sv */
// Detects a zero divisor or a quotient too wide for its destination
`timescale 1ns/1ps
module quotient_check #(
   parameter int W = 32
) (
   // Operands
   input  wire logic [2*W-1:0] dividend,
   input  wire logic [W-1:0]   divisor,
   input  wire logic           is_signed,
   // Result
   output logic                fault
);

   function automatic logic [2*W-1:0] mag2(input logic [2*W-1:0] x);
      mag2 = x[2*W-1] ? (~x + 1'b1) : x;
   endfunction : mag2

   function automatic logic [W-1:0] mag1(input logic [W-1:0] x);
      mag1 = x[W-1] ? (~x + 1'b1) : x;
   endfunction : mag1

   logic [2*W-1:0] dd_mag;
   logic [W-1:0]   dv_mag;
   logic [2*W:0]   lim_pos;
   logic [2*W:0]   lim_neg;
   logic           neg_q;
   logic           u_fault;
   logic           s_fault;

   // Quotient fits in M iff dividend < divisor * (M + 1)
   assign dd_mag  = mag2(dividend);
   assign dv_mag  = mag1(divisor);
   assign neg_q   = dividend[2*W-1] ^ divisor[W-1];
   assign lim_pos = {2'b00, dv_mag, {(W-1){1'b0}}};
   assign lim_neg = lim_pos + {{(W+1){1'b0}}, dv_mag};
   assign u_fault = dividend[2*W-1:W] >= divisor;
   assign s_fault = {1'b0, dd_mag} >= (neg_q ? lim_neg : lim_pos);
   assign fault   = (divisor == '0) | (is_signed ? s_fault : u_fault);

endmodule : quotient_check

/* File: rtl/arith_flags.sv */
// Carry and signed overflow of an addition or subtraction
`timescale 1ns/1ps
module arith_flags #(
   parameter int W = 32
) (
   // Operands
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         sub,
   // Flags
   output logic              carry,
   output logic              ovf
);

   logic [W:0] sum;
   logic [W:0] diff;

   assign sum   = {1'b0, a} + {1'b0, b};
   assign diff  = {1'b0, a} - {1'b0, b};
   assign carry = sub ? diff[W] : sum[W];
   assign ovf   = sub ? ((a[W-1] != b[W-1]) & (diff[W-1] != a[W-1]))
                      : ((a[W-1] == b[W-1]) & (sum[W-1] != a[W-1]));

endmodule : arith_flags

/* File: tb/pipeline_model.sv */
// Pipeline and delivery side model facing the exception unit
`timescale 1ns/1ps
module pipeline_model (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // Delivery pacing
   input  wire logic                   slow,
   // Instruction offer
   output low_vector_pkg::instr_info_t instr,
   output low_vector_pkg::debug_cond_t dbg,
   output logic                        instr_valid,
   input  wire logic                   instr_ready,
   // Exception delivery
   input  wire logic                   exc_req_valid,
   output logic                        exc_req_ready
);
   logic [3:0] wait_cnt;

   initial begin
      instr       = '0;
      dbg         = '0;
      instr_valid = 1'b0;
   end

   // Held until an edge sees ready, then scrambled
   task automatic offer(input low_vector_pkg::instr_info_t i,
                        input low_vector_pkg::debug_cond_t d);
      @(negedge core_clk);
      instr       = i;
      dbg         = d;
      instr_valid = 1'b1;
      while (instr_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      instr       = ~i;
      dbg         = ~d;
      instr_valid = 1'b0;
   endtask : offer

   // Takes at once, or after a wait when slow
   always @(negedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_cnt      <= 4'h0;
         exc_req_ready <= 1'b0;
      end else if (!exc_req_valid || exc_req_ready) begin
         wait_cnt      <= 4'h0;
         exc_req_ready <= !slow && exc_req_valid;
      end else begin
         wait_cnt      <= wait_cnt + 4'h1;
         exc_req_ready <= !slow || wait_cnt >= 4'h2;
      end
   end
endmodule : pipeline_model

/* File: tb/tb_low_vector_exception_unit.sv */
// Self-checking bench of the low vector exception unit
`timescale 1ns/1ps
`include "low_vector_defines.svh"
module tb_low_vector_exception_unit;
   localparam logic [7:0] BRK = 8'hfe;
   logic                        core_clk;
   logic                        arst_n;
   logic                        slow;
   logic                        nmi_pin;
   logic                        lic_nmi_req;
   logic [5:0]                  debug_status_clr;
   low_vector_pkg::instr_info_t instr;
   low_vector_pkg::debug_cond_t dbg;
   logic                        instr_valid;
   logic                        instr_ready;
   logic                        instr_commit;
   logic                        instr_squash;
   low_vector_pkg::exc_req_t    exc_req;
   logic                        exc_req_valid;
   logic                        exc_req_ready;
   low_vector_pkg::debug_cond_t debug_status_reg;
   low_vector_pkg::flags_t      processor_flags_reg;
   low_vector_pkg::exc_req_t    seen_q[$];
   int                          failures;
   int                          check_count;
   int                          cycles;

   low_vector_exception_unit #(.BRK_OPCODE(BRK)) i_low_vector_exception_unit (
      .core_clk(core_clk), .arst_n(arst_n), .instr(instr), .dbg(dbg),
      .instr_valid(instr_valid), .instr_ready(instr_ready),
      .instr_commit(instr_commit), .instr_squash(instr_squash),
      .nmi_pin(nmi_pin), .lic_nmi_req(lic_nmi_req), .exc_req(exc_req),
      .exc_req_valid(exc_req_valid), .exc_req_ready(exc_req_ready),
      .debug_status_clr(debug_status_clr),
      .debug_status_reg(debug_status_reg),
      .processor_flags_reg(processor_flags_reg));

   pipeline_model i_pipeline_model (
      .core_clk(core_clk), .arst_n(arst_n), .slow(slow), .instr(instr),
      .dbg(dbg), .instr_valid(instr_valid), .instr_ready(instr_ready),
      .exc_req_valid(exc_req_valid), .exc_req_ready(exc_req_ready));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   // Delivered requests and the hang limit
   always @(posedge core_clk) begin
      cycles++;
      if (exc_req_valid === 1'b1 && exc_req_ready === 1'b1)
         seen_q.push_back(exc_req);
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Next address is three bytes on
   function automatic low_vector_pkg::instr_info_t mk(
      input low_vector_pkg::op_t op, input logic [7:0] opc,
      input logic [7:0] imm, input logic [31:0] addr,
      input logic [31:0] hi, input logic [31:0] a, input logic [31:0] b);
      mk = {addr, addr + 32'h3, op, opc, imm, hi, a, b};
   endfunction : mk

   task automatic run(input low_vector_pkg::instr_info_t i,
                      input logic [5:0] d, input logic ok);
      i_pipeline_model.offer(i, d);
      check(instr_commit, ok);
      check(instr_squash, !ok);
   endtask : run

   task automatic expect_exc(input logic [7:0] vec,
                             input low_vector_pkg::exc_class_t cls,
                             input logic [31:0] addr);
      low_vector_pkg::exc_req_t r;
      int                       n;
      n = 0;
      while (seen_q.size() == 0 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      check(seen_q.size(), 1);
      if (seen_q.size() != 0) begin
         r = seen_q.pop_front();
         check(r.vector, vec);
         check(r.cls, cls);
         check(r.err_code_valid, 0);
         check(r.save_addr, addr);
      end
   endtask : expect_exc

   task automatic quiet;
      repeat (8) @(negedge core_clk);
      check(seen_q.size(), 0);
   endtask : quiet

   task automatic t_divide;
      run(mk(low_vector_pkg::op_udiv, 8'hf7, 8'h0, 32'h1000,
             32'h0, 32'ha, 32'h0), 6'h0, 1'b0);
      expect_exc(`VEC_QUOTIENT, low_vector_pkg::cls_fault, 32'h1000);
      run(mk(low_vector_pkg::op_udiv, 8'hf7, 8'h0, 32'h1010,
             32'h1, 32'h0, 32'h1), 6'h0, 1'b0);
      expect_exc(`VEC_QUOTIENT, low_vector_pkg::cls_fault, 32'h1010);
      run(mk(low_vector_pkg::op_sdiv, 8'hf7, 8'h0, 32'h1020,
             32'h0, 32'h8000_0000, 32'h1), 6'h0, 1'b0);
      expect_exc(`VEC_QUOTIENT, low_vector_pkg::cls_fault, 32'h1020);
      run(mk(low_vector_pkg::op_sdiv, 8'hf7, 8'h0, 32'h1030,
             32'hffff_ffff, 32'hffff_fff6, 32'h5), 6'h0, 1'b1);
      quiet();
      $display("test divide done");
   endtask : t_divide

   task automatic t_debug;
      logic        flt;
      logic [31:0] a;
      for (int k = 0; k < 6; k++) begin
         flt = (k == 0 || k == 3);
         a   = 32'h2000 + 32'h10 * k;
         run(mk(low_vector_pkg::op_other, 8'h90, 8'h0, a, 32'h0, 32'h0,
                32'h0), 6'h1 << k, !flt);
         expect_exc(`VEC_DEBUG, flt ? low_vector_pkg::cls_fault :
                    low_vector_pkg::cls_trap, flt ? a : a + 32'h3);
         check(debug_status_reg, 6'h1 << k);
         @(negedge core_clk);
         debug_status_clr = 6'h3f;
         @(negedge core_clk);
         debug_status_clr = 6'h0;
         check(debug_status_reg, `DEBUG_STATUS_RST);
      end
      $display("test debug done");
   endtask : t_debug

   task automatic t_soft_traps;
      run(mk(low_vector_pkg::op_add, 8'h01, 8'h0, 32'h3000, 32'h0,
             32'h7fff_ffff, 32'h1), 6'h0, 1'b1);
      check(processor_flags_reg, 2'h2);
      run(mk(low_vector_pkg::op_into, 8'hce, 8'h0, 32'h3010, 32'h0, 32'h0,
             32'h0), 6'h0, 1'b1);
      expect_exc(`VEC_OVERFLOW, low_vector_pkg::cls_trap, 32'h3013);
      run(mk(low_vector_pkg::op_other, BRK, 8'h0, 32'h3020, 32'h0, 32'h0,
             32'h0), 6'h0, 1'b1);
      expect_exc(`VEC_BREAKPOINT, low_vector_pkg::cls_trap, 32'h3021);
      check(processor_flags_reg, 2'h2);
      run(mk(low_vector_pkg::op_intn, 8'hcd, `INTN_BRK_IMM, 32'h3030, 32'h0,
             32'h0, 32'h0), 6'h0, 1'b1);
      expect_exc(`VEC_BREAKPOINT, low_vector_pkg::cls_trap, 32'h3033);
      run(mk(low_vector_pkg::op_sub, 8'h29, 8'h0, 32'h3040, 32'h0, 32'h0,
             32'h1), 6'h0, 1'b1);
      check(processor_flags_reg, 2'h1);
      run(mk(low_vector_pkg::op_into, 8'hce, 8'h0, 32'h3050, 32'h0, 32'h0,
             32'h0), 6'h0, 1'b1);
      quiet();
      // Breakpoint byte over an add, single step trap queued behind it
      run(mk(low_vector_pkg::op_add, BRK, 8'h0, 32'h3060, 32'h0,
             32'h7fff_ffff, 32'h1), 6'h10, 1'b1);
      expect_exc(`VEC_BREAKPOINT, low_vector_pkg::cls_trap, 32'h3061);
      expect_exc(`VEC_DEBUG, low_vector_pkg::cls_trap, 32'h3061);
      check(processor_flags_reg, 2'h1);
      check(debug_status_reg, 6'h10);
      $display("test soft traps done");
   endtask : t_soft_traps

   task automatic t_nmi;
      run(mk(low_vector_pkg::op_add, 8'h01, 8'h0, 32'h4000, 32'h0, 32'h1,
             32'h1), 6'h0, 1'b1);
      @(negedge core_clk);
      lic_nmi_req = 1'b1;
      @(negedge core_clk);
      lic_nmi_req = 1'b0;
      expect_exc(`VEC_NMI, low_vector_pkg::cls_none, 32'h4003);
      nmi_pin = 1'b1;
      repeat (12) @(negedge core_clk);
      nmi_pin = 1'b0;
      expect_exc(`VEC_NMI, low_vector_pkg::cls_none, 32'h4003);
      quiet();
      slow = 1'b1;
      fork
         run(mk(low_vector_pkg::op_add, 8'h01, 8'h0, 32'h4010, 32'h0,
                32'h2, 32'h2), 6'h0, 1'b1);
         begin
            @(negedge core_clk);
            lic_nmi_req = 1'b1;
            @(negedge core_clk);
            lic_nmi_req = 1'b0;
         end
      join
      expect_exc(`VEC_NMI, low_vector_pkg::cls_none, 32'h4013);
      slow = 1'b0;
      $display("test nmi done");
   endtask : t_nmi

   initial begin
      arst_n           = 1'b0;
      slow             = 1'b0;
      nmi_pin          = 1'b0;
      lic_nmi_req      = 1'b0;
      debug_status_clr = 6'h0;
      failures         = 0;
      check_count      = 0;
      cycles           = 0;
      repeat (16) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      check(processor_flags_reg, `FLAGS_RST);
      check(debug_status_reg, `DEBUG_STATUS_RST);
      check(instr_ready, 1'b1);
      t_divide();
      t_debug();
      t_soft_traps();
      t_nmi();
      end_of_test();
   end
endmodule : tb_low_vector_exception_unit
